// ===== design/sld_cfg.svh
// register offsets, field positions, reset values and timing counts of the stall load detector
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

`define SLD_OFS_CTRL 8'h00
`define SLD_OFS_THRESHOLD 8'h04
`define SLD_OFS_LOW_LIMIT 8'h08
`define SLD_OFS_HIGH_LIMIT 8'h0c
`define SLD_OFS_LOAD 8'h10
`define SLD_OFS_INTERVAL 8'h14
`define SLD_OFS_INT_STATUS 8'h18
`define SLD_OFS_INT_CLEAR 8'h1c
`define SLD_OFS_INT_ENABLE 8'h20

`define SLD_CTRL_SILENT_BIT 0
`define SLD_INT_STALL_BIT 0
`define SLD_INT_UPDATE_BIT 1

`define SLD_LOAD_MAX 10'h1fe
`define SLD_RST_CTRL 1'h0
`define SLD_RST_THRESHOLD 8'h00
`define SLD_RST_LOW_LIMIT 20'h00000
`define SLD_RST_HIGH_LIMIT 20'h00000
`define SLD_RST_INT_ENABLE 2'h0

`define SLD_PULSE_NS 160
`define SLD_CLK_NS 40
`define SLD_PULSE_CYCLES ((`SLD_PULSE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

`endif

// ===== design/sld_pkg.sv
// types shared by the stall load detector
`default_nettype none
package sld_pkg;
	typedef logic [9:0] sld_load_type;
	typedef logic [1:0] sld_irq_type;
	typedef enum logic {SLD_BUS_IDLE, SLD_BUS_ACK} sld_bus_type;
endpackage : sld_pkg
`default_nettype wire

// ===== design/sld_top.sv
// stall load detector: load measurement latch, stall comparator, diagnostic pulse and wishbone registers
// What this block does
// - load measurement unsigned, 0 to 510, higher lighter
// - stall when measurement below doubled threshold
// - larger threshold flags stall at lower torque
// - stall gives pulse on fault pin, not level
// - pulse only silent mode, low>=interval>high
// - measurement refreshed once per full step
// - low limit compared directly against step interval
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`default_nettype none
`include "sld_cfg.svh"
module sld_top #(
	parameter int INTERVAL_W = 20,
	parameter int THRESHOLD_W = 8,
	parameter int PULSE_CYCLES = `SLD_PULSE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic step_i,
	input wire logic full_step_i,
	input wire logic [9:0] load_sample_i,
	output logic fault_indicator_pin_o,
	output logic irq_o
);
	localparam logic [INTERVAL_W-1:0] INTERVAL_MAX = '1;

	// address decode shared by read and write paths
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction : hit

	// bus slave state
	sld_pkg::sld_bus_type bus_ff, nxt_bus;
	logic [31:0] dat_ff, nxt_dat;
	logic wr_en;

	// configuration
	logic silent_ff, nxt_silent;
	logic [THRESHOLD_W-1:0] stall_threshold_ff, nxt_stall_threshold;
	logic [INTERVAL_W-1:0] low_velocity_limit_ff, nxt_low_velocity_limit;
	logic [INTERVAL_W-1:0] high_velocity_limit_ff, nxt_high_velocity_limit;
	sld_pkg::sld_irq_type int_enable_ff, nxt_int_enable;
	sld_pkg::sld_irq_type int_status_ff, nxt_int_status;
	logic irq_ff, nxt_irq;

	// measurement and detection
	logic [INTERVAL_W-1:0] step_count_ff, nxt_step_count;
	logic [INTERVAL_W-1:0] step_interval_measure_ff, nxt_step_interval_measure;
	sld_pkg::sld_load_type load_measurement_ff, nxt_load_measurement;
	logic eval_ff, nxt_eval;
	logic [7:0] pulse_cnt_ff, nxt_pulse_cnt;
	logic pin_ff, nxt_pin;
	logic gate_ok;
	logic below;
	logic fire;
	sld_pkg::sld_load_type doubled;

	assign wr_en = cyc_i && stb_i && we_i && (bus_ff == sld_pkg::SLD_BUS_ACK);

	always_comb begin
		nxt_bus = sld_pkg::SLD_BUS_IDLE;
		nxt_dat = 32'h00000000;
		unique case (bus_ff)
			sld_pkg::SLD_BUS_IDLE: begin
				if (cyc_i && stb_i) begin
					nxt_bus = sld_pkg::SLD_BUS_ACK;
					if (hit(adr_i, `SLD_OFS_CTRL)) nxt_dat[`SLD_CTRL_SILENT_BIT] = silent_ff;
					if (hit(adr_i, `SLD_OFS_THRESHOLD)) nxt_dat[THRESHOLD_W-1:0] = stall_threshold_ff;
					if (hit(adr_i, `SLD_OFS_LOW_LIMIT)) nxt_dat[INTERVAL_W-1:0] = low_velocity_limit_ff;
					if (hit(adr_i, `SLD_OFS_HIGH_LIMIT)) nxt_dat[INTERVAL_W-1:0] = high_velocity_limit_ff;
					if (hit(adr_i, `SLD_OFS_LOAD)) nxt_dat[9:0] = load_measurement_ff;
					if (hit(adr_i, `SLD_OFS_INTERVAL)) nxt_dat[INTERVAL_W-1:0] = step_interval_measure_ff;
					if (hit(adr_i, `SLD_OFS_INT_STATUS)) nxt_dat[1:0] = int_status_ff;
					if (hit(adr_i, `SLD_OFS_INT_ENABLE)) nxt_dat[1:0] = int_enable_ff;
				end
			end
			sld_pkg::SLD_BUS_ACK: begin
				// read data stands for the ack cycle only
				nxt_bus = sld_pkg::SLD_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_ff <= sld_pkg::SLD_BUS_IDLE;
			dat_ff <= 32'h00000000;
		end else begin
			bus_ff <= nxt_bus;
			dat_ff <= nxt_dat;
		end
	end

	assign ack_o = (bus_ff == sld_pkg::SLD_BUS_ACK);
	assign dat_o = dat_ff;

	// register writes take effect at the edge that samples ack
	always_comb begin
		nxt_silent = silent_ff;
		nxt_stall_threshold = stall_threshold_ff;
		nxt_low_velocity_limit = low_velocity_limit_ff;
		nxt_high_velocity_limit = high_velocity_limit_ff;
		nxt_int_enable = int_enable_ff;
		nxt_int_status = int_status_ff;
		if (wr_en && sel_i[0] && hit(adr_i, `SLD_OFS_CTRL)) nxt_silent = dat_i[`SLD_CTRL_SILENT_BIT];
		if (wr_en && sel_i[0] && hit(adr_i, `SLD_OFS_THRESHOLD)) nxt_stall_threshold = dat_i[THRESHOLD_W-1:0];
		if (wr_en && hit(adr_i, `SLD_OFS_LOW_LIMIT)) begin
			for (int b = 0; b < INTERVAL_W; b++) begin
				if (sel_i[b/8]) nxt_low_velocity_limit[b] = dat_i[b];
			end
		end
		if (wr_en && hit(adr_i, `SLD_OFS_HIGH_LIMIT)) begin
			for (int b = 0; b < INTERVAL_W; b++) begin
				if (sel_i[b/8]) nxt_high_velocity_limit[b] = dat_i[b];
			end
		end
		if (wr_en && sel_i[0] && hit(adr_i, `SLD_OFS_INT_ENABLE)) nxt_int_enable = dat_i[1:0];
		if (wr_en && sel_i[0] && hit(adr_i, `SLD_OFS_INT_CLEAR)) nxt_int_status = int_status_ff & ~dat_i[1:0];
		// events win over a clear in the same cycle
		if (fire) nxt_int_status[`SLD_INT_STALL_BIT] = 1'b1;
		if (eval_ff) nxt_int_status[`SLD_INT_UPDATE_BIT] = 1'b1;
		nxt_irq = |(nxt_int_status & nxt_int_enable);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			silent_ff <= `SLD_RST_CTRL;
			stall_threshold_ff <= `SLD_RST_THRESHOLD;
			low_velocity_limit_ff <= `SLD_RST_LOW_LIMIT;
			high_velocity_limit_ff <= `SLD_RST_HIGH_LIMIT;
			int_enable_ff <= `SLD_RST_INT_ENABLE;
			int_status_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			silent_ff <= nxt_silent;
			stall_threshold_ff <= nxt_stall_threshold;
			low_velocity_limit_ff <= nxt_low_velocity_limit;
			high_velocity_limit_ff <= nxt_high_velocity_limit;
			int_enable_ff <= nxt_int_enable;
			int_status_ff <= nxt_int_status;
			irq_ff <= nxt_irq;
		end
	end

	assign irq_o = irq_ff;

	// step interval, load latch and stall pulse
	assign doubled = sld_pkg::sld_load_type'({stall_threshold_ff[THRESHOLD_W-1:0], 1'b0});
	assign below = load_measurement_ff < doubled;
	assign gate_ok = silent_ff && (low_velocity_limit_ff >= step_interval_measure_ff)
		&& (step_interval_measure_ff > high_velocity_limit_ff);
	assign fire = eval_ff && gate_ok && below;

	always_comb begin
		nxt_step_count = (step_count_ff == INTERVAL_MAX) ? step_count_ff : step_count_ff + 1'b1;
		nxt_step_interval_measure = step_interval_measure_ff;
		if (step_i) begin
			nxt_step_interval_measure = nxt_step_count;
			nxt_step_count = '0;
		end
		nxt_load_measurement = load_measurement_ff;
		if (full_step_i) begin
			nxt_load_measurement = (load_sample_i > `SLD_LOAD_MAX) ? `SLD_LOAD_MAX : load_sample_i;
		end
		nxt_eval = full_step_i;
		nxt_pulse_cnt = (pulse_cnt_ff != 8'h00) ? pulse_cnt_ff - 8'h01 : 8'h00;
		if (fire) nxt_pulse_cnt = 8'(PULSE_CYCLES);
		nxt_pin = (nxt_pulse_cnt != 8'h00);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_count_ff <= '0;
			step_interval_measure_ff <= '1;
			load_measurement_ff <= 10'h000;
			eval_ff <= 1'b0;
			pulse_cnt_ff <= 8'h00;
			pin_ff <= 1'b0;
		end else begin
			step_count_ff <= nxt_step_count;
			step_interval_measure_ff <= nxt_step_interval_measure;
			load_measurement_ff <= nxt_load_measurement;
			eval_ff <= nxt_eval;
			pulse_cnt_ff <= nxt_pulse_cnt;
			pin_ff <= nxt_pin;
		end
	end

	assign fault_indicator_pin_o = pin_ff;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);


	// measurement range and latch
	a_load_in_range: assert property (load_measurement_ff <= `SLD_LOAD_MAX)
		else $error("load measurement above 510");
	a_load_latch: assert property (full_step_i
		|=> load_measurement_ff == (($past(load_sample_i) > `SLD_LOAD_MAX) ? `SLD_LOAD_MAX : $past(load_sample_i)))
		else $error("load measurement not latched on a full step");
	a_load_held: assert property (!full_step_i
		|=> $stable(load_measurement_ff))
		else $error("load measurement changed off a full step");

	// stall comparison against the doubled threshold
	a_stall_fires: assert property (eval_ff && gate_ok
		&& (load_measurement_ff < {stall_threshold_ff, 1'b0})
		|=> fault_indicator_pin_o)
		else $error("stall below doubled threshold gave no pulse");
	a_no_false_stall: assert property ($rose(fault_indicator_pin_o)
		|-> $past(load_measurement_ff) < $past({stall_threshold_ff, 1'b0}))
		else $error("pulse without measurement below threshold");
	a_strict_less: assert property (eval_ff && gate_ok
		&& load_measurement_ff == {stall_threshold_ff, 1'b0}
		&& pulse_cnt_ff == 8'h00 |=> !fault_indicator_pin_o)
		else $error("equal measurement flagged a stall");

	// pulse shape on the fault pin
	a_pulse_shape: assert property ($rose(fault_indicator_pin_o) && PULSE_CYCLES == 4
		|-> fault_indicator_pin_o[*4])
		else $error("fault pulse too short");
	a_pulse_end: assert property ($rose(fault_indicator_pin_o) && PULSE_CYCLES == 4 ##0 !fire[*4]
		|=> !fault_indicator_pin_o)
		else $error("fault pulse too long");

	// mode and velocity window gating
	a_pulse_gated: assert property ($rose(fault_indicator_pin_o)
		|-> $past(silent_ff)
		&& $past(low_velocity_limit_ff >= step_interval_measure_ff)
		&& $past(step_interval_measure_ff > high_velocity_limit_ff))
		else $error("pulse outside allowed mode or velocity window");
	a_silent_gate: assert property (!silent_ff && pulse_cnt_ff == 8'h00
		|=> !fault_indicator_pin_o)
		else $error("pulse outside silent mode");
	a_low_gate: assert property (eval_ff && (low_velocity_limit_ff < step_interval_measure_ff)
		&& pulse_cnt_ff == 8'h00 |=> !fault_indicator_pin_o)
		else $error("pulse below low velocity limit");
	a_high_gate: assert property (eval_ff && (step_interval_measure_ff <= high_velocity_limit_ff)
		&& pulse_cnt_ff == 8'h00 |=> !fault_indicator_pin_o)
		else $error("pulse above high velocity limit");
	a_eval_only: assert property (!eval_ff && pulse_cnt_ff == 8'h00
		|=> !fault_indicator_pin_o)
		else $error("pulse without a full step");

	// step interval capture
	a_interval_taken: assert property (step_i && step_count_ff < INTERVAL_MAX
		|=> step_interval_measure_ff == $past(step_count_ff) + 1'b1)
		else $error("step interval not captured");
	a_interval_sat: assert property (step_i && step_count_ff == INTERVAL_MAX
		|=> step_interval_measure_ff == INTERVAL_MAX)
		else $error("step interval did not saturate");

	// status and interrupt
	a_stall_status: assert property (fire
		|=> int_status_ff[`SLD_INT_STALL_BIT])
		else $error("stall event not recorded");
	a_update_status: assert property (eval_ff
		|=> int_status_ff[`SLD_INT_UPDATE_BIT])
		else $error("new measurement not recorded");
	a_irq_level: assert property (int_status_ff[`SLD_INT_STALL_BIT] && int_enable_ff[`SLD_INT_STALL_BIT]
		|-> irq_o)
		else $error("enabled stall status without interrupt");
	a_irq_off: assert property (!(|(int_status_ff & int_enable_ff))
		|-> !irq_o)
		else $error("interrupt without enabled status");

	// register bus
	a_ack_one: assert property (ack_o |=> !ack_o)
		else $error("ack held more than one cycle");
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o
		|=> ack_o)
		else $error("request not acknowledged");
	a_dat_idle: assert property (!ack_o
		|-> dat_o == 32'h00000000)
		else $error("read data outside ack cycle");

	// main scenarios
	c_stall_pulse: cover property ($rose(fault_indicator_pin_o));
	c_stall_irq: cover property (fire ##[1:4] irq_o);
	c_gate_blocked: cover property (eval_ff && below && !gate_ok);
	c_equal_blocked: cover property (eval_ff && gate_ok && load_measurement_ff == doubled);
	c_bus_write: cover property (wr_en);
endmodule : sld_top
`default_nettype wire

// ===== testbench/sld_motion_ctrl.sv
// motion controller model: steps at a fixed period and halts on a stall pulse
`default_nettype none
module sld_motion_ctrl #(
	parameter int PERIOD = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic stall_i,
	output logic step_o,
	output logic full_step_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	logic halt;
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt <= 0;
			halt <= 1'h0;
			step_o <= 1'h0;
		end else begin
			if (stall_i) halt <= 1'h1;
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			step_o <= (cnt == PERIOD - 1) && !halt && !stall_i;
		end
	end
	assign full_step_o = step_o;
endmodule : sld_motion_ctrl
`default_nettype wire

// ===== testbench/stall_load_detector_tb.sv
// testbench of the stall load detector
`default_nettype none
`include "sld_cfg.svh"
module stall_load_detector_tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
	localparam int P = 20;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, run = 1'h0;
	logic ack_o, step_i, full_step_i, fault_indicator_pin_o, irq_o;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic [9:0] load_sample_i = 10'h000;
	int bad_count = 0, checks_done = 0, pulses = 0, len = 0, last_w = 0;
	logic [3:0] tc [7] = '{4'hf, 4'hb, 4'he, 4'hd, 4'h7, 4'hf, 4'hf};
	logic [9:0] tl [7] = '{10'h014, 10'h014, 10'h014, 10'h014, 10'h014, 10'h016, 10'h3ff};
	always #20 clk_i = ~clk_i;
	sld_top sld_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.step_i, .full_step_i, .load_sample_i, .fault_indicator_pin_o, .irq_o);
	sld_motion_ctrl #(.PERIOD(P)) sld_motion_ctrl_i (.clk_i, .rst_i, .run_i(run),
		.stall_i(fault_indicator_pin_o), .step_o(step_i), .full_step_o(full_step_i));
	always @(posedge clk_i) begin
		if (fault_indicator_pin_o === 1'h1) len++;
		else if (len != 0) begin
			last_w = len;
			pulses++;
			len = 0;
		end
	end
	task automatic results();
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic got;
		n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		got = (ack_o === 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
		if (!got) begin
			bad_count++;
			$display("BAD %0t bus timeout", $time);
			results();
		end
	endtask : wb
	function automatic logic [9:0] sat(input logic [9:0] v);
		return (v > 10'h1fe) ? 10'h1fe : v;
	endfunction : sat
	// c holds irq enable, silent mode, low limit ok, high limit ok
	task automatic trial(input logic [3:0] c, input logic [7:0] thr, input logic [9:0] ld);
		logic exp;
		exp = c[2] && c[1] && c[0] && (sat(ld) < {thr, 1'h0});
		run <= 1'h0;
		wb(1'h1, `SLD_OFS_CTRL, {31'h0, c[2]});
		wb(1'h1, `SLD_OFS_THRESHOLD, {24'h0, thr});
		wb(1'h1, `SLD_OFS_LOW_LIMIT, c[1] ? 32'(P) : 32'(P - 1));
		wb(1'h1, `SLD_OFS_HIGH_LIMIT, c[0] ? 32'(P - 1) : 32'(P));
		wb(1'h1, `SLD_OFS_INT_ENABLE, {31'h0, c[3]});
		load_sample_i <= ld;
		run <= 1'h1;
		pulses = 0;
		repeat (3 * P + 10) @(posedge clk_i);
		`CHK(pulses, int'(exp))
		if (exp) `CHK(last_w, 4)
		`CHK(irq_o, exp & c[3])
		run <= 1'h0;
		load_sample_i <= ~ld;
		wb(1'h0, `SLD_OFS_LOAD, 32'h0);
		`CHK(q[9:0], sat(ld))
		wb(1'h0, `SLD_OFS_INTERVAL, 32'h0);
		`CHK(q[19:0], 20'(P))
		wb(1'h0, `SLD_OFS_INT_STATUS, 32'h0);
		`CHK(q[0], exp)
		`CHK(q[1], 1'h1)
		wb(1'h1, `SLD_OFS_INT_CLEAR, 32'h3);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'h0)
		$display("trial %h %h %h done", c, thr, ld);
	endtask : trial
	initial begin
		void'($urandom(33391));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, `SLD_OFS_INTERVAL, 32'h0);
		`CHK(q, 32'h000fffff)
		wb(1'h0, `SLD_OFS_LOAD, 32'h0);
		`CHK(q, 32'h0)
		wb(1'h0, 8'h24, 32'h0);
		`CHK(q, 32'h0)
		$display("reset test done");
		for (int i = 0; i < 7; i++) trial(tc[i], (i == 6) ? 8'hff : 8'h0b, tl[i]);
		for (int i = 0; i < 12; i++) trial({1'($urandom_range(1)), 3'h7}, 8'($urandom), 10'($urandom_range(600)));
		results();
	end
endmodule : stall_load_detector_tb
`default_nettype wire
